// ---- hw/dtx_timers.sv ----
// How it works
// - edge select 01 rising, 10 falling (reset), 11 both, 00 never triggers
// - with both enables set, each selected pin edge sets the request flag
// - pending enabled external request presents vector 0x0003 to the cpu
// - cpu acknowledge of the external request clears its flag
// - enable register bit 7 is the global enable, reset 0
// - enable register bit 0 enables the external interrupt, reset 0
// - control register bit 1 is the external request flag, read/write
// - timer 0 has four modes, timer 1 modes 0 to 2
// - tick from cpu/12 or divided oscillator; timer 0 gate pauses on pin
// - mode 0 counts 13 bits, flag set on wrap from 0xff1f
// - overflow flag writable by firmware only while its enable is off
// - mode 1 counts 16 bits, flag set on wrap from 0xffff
// - mode 2 low byte wraps, sets flag and reloads from high byte
// - mode 3 splits timer 0: low byte selectable, high byte cpu/12
// - in mode 3 only the low-byte counter is gated by the pin
// - mode 3: run 0 drives low byte/flag 0, run 1 high byte/flag 1
// - while timer 0 is in mode 3, timer 1 counts without any flag
// - mode field 00 13-bit, 01 16-bit, 10 8-bit reload
// - overflow flag cleared by interrupt service or firmware write
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module dtx_timers (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // external pin and oscillator tick, both synchronous to core_clk
  input  wire logic        ext_irq_pin,
  input  wire logic        osc_tick,
  // interrupt controller side
  input  wire logic        ext_irq_ack,
  input  wire logic        timer0_irq_ack,
  input  wire logic        timer1_irq_ack,
  output logic             ext_irq_req,
  output logic             timer0_irq_req,
  output logic             timer1_irq_req,
  output logic [15:0]      irq_vector
);

  typedef struct packed {
    logic [7:0]  timer0_low_byte;
    logic [7:0]  timer0_high_byte;
    logic [7:0]  timer1_low_byte;
    logic [7:0]  timer1_high_byte;
    logic        timer0_overflow_flag;
    logic        timer1_overflow_flag;
    logic        timer0_run;
    logic        timer1_run;
    logic        ext_irq_request_flag;
    logic [6:0]  tmod;
    logic [2:0]  rate0;
    logic [2:0]  rate1;
    logic [1:0]  ext_irq_edge_sel;
    logic        global_irq_enable;
    logic        timer1_irq_enable;
    logic        timer0_irq_enable;
    logic        ext_irq_enable;
    logic        pin_q;
    logic [3:0]  pre_cnt;
    logic        cpu_tick;
    logic        ack;
    logic [31:0] rdata;
    logic        ext_req;
    logic        t0_req;
    logic        t1_req;
    logic [15:0] vector;
  } dtx_state_s;

  dtx_state_s       s;
  dtx_state_s       next_s;

  logic [1:0][2:0]  rate_sel;
  logic [1:0]       osc_div_tick;

  logic             req;
  logic             hit;
  logic             wr;
  logic [7:0]       idx;
  logic [7:0]       wbyte;
  logic [7:0]       rd;
  logic [1:0]       mode0;
  logic [1:0]       mode1;
  logic             split;
  logic             gate_ok;
  logic             t0_tick;
  logic             t1_tick;
  logic [16:0]      step0;
  logic [16:0]      step1;
  logic             ov_t0;
  logic             ov_t1;
  logic             ov_th0;
  logic             rise;
  logic             fall;
  logic             edge_hit;

  // one increment of a timer pair in modes 0 to 2; {overflow, high, low}
  function automatic logic [16:0] dtx_step(
    input logic [7:0] th,
    input logic [7:0] tl,
    input logic [1:0] mode
  );
    logic [16:0] r;
    r = {1'b0, th, tl};
    unique case (mode)
      dtx_pkg::MODE_13BIT: begin
        // upper three low-byte bits stay as they are
        if (tl[4:0] == dtx_pkg::M0_LOW_TOP) begin
          r[4:0] = '0;
          r[15:8] = th + 8'h01;
          r[16] = (th == dtx_pkg::BYTE_MAX);
        end else begin
          r[4:0] = tl[4:0] + 5'h01;
        end
      end
      dtx_pkg::MODE_16BIT: begin
        r[15:0] = {th, tl} + 16'h0001;
        r[16] = ({th, tl} == dtx_pkg::WORD_MAX);
      end
      dtx_pkg::MODE_RELOAD8: begin
        if (tl == dtx_pkg::BYTE_MAX) begin
          r[7:0] = th;
          r[16] = 1'b1;
        end else begin
          r[7:0] = tl + 8'h01;
        end
      end
      dtx_pkg::MODE_SPLIT8: begin
        // timer 1 has no mode 3; a pair told to use it stands still
        r = {1'b0, th, tl};
      end
    endcase
    return r;
  endfunction : dtx_step

  assign rate_sel[0] = s.rate0;
  assign rate_sel[1] = s.rate1;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_div
    dtx_osc_div u_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .osc_tick (osc_tick),
      .rate     (rate_sel[g]),
      .tick     (osc_div_tick[g])
    );
  end

  always_comb begin
    next_s = s;

    // bus decode
    req = wb_cyc_i & wb_stb_i;
    hit = (wb_adr_i[11:10] == 2'h0);
    idx = wb_adr_i[9:2];
    wbyte = wb_dat_i[7:0];
    // a write lands on the edge where the master sees ack high
    wr = req & wb_we_i & s.ack & wb_sel_i[0] & hit;

    // read mux; unmapped indices and reserved bits read zero
    rd = '0;
    if (hit) begin
      unique case (idx)
        dtx_pkg::IDX_CTL:   rd = {s.timer1_overflow_flag, s.timer1_run,
                                  s.timer0_overflow_flag, s.timer0_run,
                                  2'h0, s.ext_irq_request_flag, 1'b0};
        dtx_pkg::IDX_TMOD:  rd = {1'b0, s.tmod};
        dtx_pkg::IDX_LO0:   rd = s.timer0_low_byte;
        dtx_pkg::IDX_LO1:   rd = s.timer1_low_byte;
        dtx_pkg::IDX_HI0:   rd = s.timer0_high_byte;
        dtx_pkg::IDX_HI1:   rd = s.timer1_high_byte;
        dtx_pkg::IDX_EDGE:  rd = {6'h00, s.ext_irq_edge_sel};
        dtx_pkg::IDX_IRQEN: rd = {s.global_irq_enable, 3'h0,
                                  s.timer1_irq_enable, 1'b0,
                                  s.timer0_irq_enable, s.ext_irq_enable};
        dtx_pkg::IDX_TCON0: rd = {1'b0, s.rate0, 1'b0, s.rate1};
        default:            rd = '0;
      endcase
    end

    next_s.ack = req & ~s.ack;
    if (req & ~s.ack) begin
      next_s.rdata = {24'h000000, rd};
    end

    // cpu/12 prescaler
    next_s.cpu_tick = 1'b0;
    if (s.pre_cnt == dtx_pkg::CPU_DIV_LAST) begin
      next_s.pre_cnt = '0;
      next_s.cpu_tick = 1'b1;
    end else begin
      next_s.pre_cnt = s.pre_cnt + 4'h1;
    end

    // clock source and gate
    mode0 = s.tmod[dtx_pkg::TMOD_T0M_LSB +: 2];
    mode1 = s.tmod[dtx_pkg::TMOD_M1_LSB +: 2];
    split = (mode0 == dtx_pkg::MODE_SPLIT8);
    gate_ok = ~s.tmod[dtx_pkg::TMOD_GATE0] | ext_irq_pin;
    t0_tick = s.tmod[dtx_pkg::TMOD_T0CT] ? osc_div_tick[0] : s.cpu_tick;
    t1_tick = s.tmod[dtx_pkg::TMOD_T1CT] ? osc_div_tick[1] : s.cpu_tick;

    // timer 0
    ov_t0 = 1'b0;
    ov_th0 = 1'b0;
    step0 = dtx_step(s.timer0_high_byte, s.timer0_low_byte, mode0);
    if (split) begin
      // low byte: own source, gated, run 0
      if (s.timer0_run & t0_tick & gate_ok) begin
        next_s.timer0_low_byte = s.timer0_low_byte + 8'h01;
        ov_t0 = (s.timer0_low_byte == dtx_pkg::BYTE_MAX);
      end
      // high byte: cpu/12, never gated, run 1
      if (s.timer1_run & s.cpu_tick) begin
        next_s.timer0_high_byte = s.timer0_high_byte + 8'h01;
        ov_th0 = (s.timer0_high_byte == dtx_pkg::BYTE_MAX);
      end
    end else if (s.timer0_run & t0_tick & gate_ok) begin
      next_s.timer0_high_byte = step0[15:8];
      next_s.timer0_low_byte = step0[7:0];
      ov_t0 = step0[16];
    end

    // timer 1; while timer 0 is split its run bit is borrowed, so it
    // runs freely and its overflow is dropped
    ov_t1 = 1'b0;
    step1 = dtx_step(s.timer1_high_byte, s.timer1_low_byte, mode1);
    if ((s.timer1_run | split) & t1_tick) begin
      next_s.timer1_high_byte = step1[15:8];
      next_s.timer1_low_byte = step1[7:0];
      ov_t1 = step1[16] & ~split;
    end

    // firmware writes to counters take priority over counting
    if (wr) begin
      unique case (idx)
        dtx_pkg::IDX_LO0: next_s.timer0_low_byte = wbyte;
        dtx_pkg::IDX_LO1: next_s.timer1_low_byte = wbyte;
        dtx_pkg::IDX_HI0: next_s.timer0_high_byte = wbyte;
        dtx_pkg::IDX_HI1: next_s.timer1_high_byte = wbyte;
        dtx_pkg::IDX_TMOD: next_s.tmod = wbyte[6:0];
        dtx_pkg::IDX_TCON0: begin
          next_s.rate0 = wbyte[dtx_pkg::TCON0_T0R_LSB +: 3];
          next_s.rate1 = wbyte[dtx_pkg::TCON0_T1R_LSB +: 3];
        end
        dtx_pkg::IDX_EDGE:
          next_s.ext_irq_edge_sel = wbyte[dtx_pkg::EDGE_SEL_LSB +: 2];
        dtx_pkg::IDX_IRQEN: begin
          next_s.global_irq_enable = wbyte[dtx_pkg::EN_ALL];
          next_s.timer1_irq_enable = wbyte[dtx_pkg::EN_T1];
          next_s.timer0_irq_enable = wbyte[dtx_pkg::EN_T0];
          next_s.ext_irq_enable = wbyte[dtx_pkg::EN_EXT];
        end
        dtx_pkg::IDX_CTL: begin
          next_s.timer1_run = wbyte[dtx_pkg::CTL_RUN1];
          next_s.timer0_run = wbyte[dtx_pkg::CTL_RUN0];
          next_s.ext_irq_request_flag = wbyte[dtx_pkg::CTL_EXT];
          // flags belong to the interrupt controller while enabled
          if (!s.timer1_irq_enable) begin
            next_s.timer1_overflow_flag = wbyte[dtx_pkg::CTL_OV1];
          end
          if (!s.timer0_irq_enable) begin
            next_s.timer0_overflow_flag = wbyte[dtx_pkg::CTL_OV0];
          end
        end
        default: begin
        end
      endcase
    end

    // service clears, then hardware sets; a set in the same cycle wins
    if (timer0_irq_ack) begin
      next_s.timer0_overflow_flag = 1'b0;
    end
    if (timer1_irq_ack) begin
      next_s.timer1_overflow_flag = 1'b0;
    end
    if (ext_irq_ack) begin
      next_s.ext_irq_request_flag = 1'b0;
    end
    if (ov_t0) begin
      next_s.timer0_overflow_flag = 1'b1;
    end
    if (ov_t1 | ov_th0) begin
      next_s.timer1_overflow_flag = 1'b1;
    end

    // external pin edge detection
    next_s.pin_q = ext_irq_pin;
    rise = ext_irq_pin & ~s.pin_q;
    fall = ~ext_irq_pin & s.pin_q;
    unique case (s.ext_irq_edge_sel)
      dtx_pkg::EDGE_RESERVED: edge_hit = 1'b0;
      dtx_pkg::EDGE_RISE:     edge_hit = rise;
      dtx_pkg::EDGE_FALL:     edge_hit = fall;
      dtx_pkg::EDGE_BOTH:     edge_hit = rise | fall;
    endcase
    if (edge_hit & s.ext_irq_enable & s.global_irq_enable) begin
      next_s.ext_irq_request_flag = 1'b1;
    end

    // requests towards the interrupt controller, gated by enables
    next_s.ext_req = s.ext_irq_request_flag & s.ext_irq_enable
                     & s.global_irq_enable;
    next_s.t0_req = s.timer0_overflow_flag & s.timer0_irq_enable
                    & s.global_irq_enable;
    next_s.t1_req = s.timer1_overflow_flag & s.timer1_irq_enable
                    & s.global_irq_enable;
    next_s.vector = next_s.ext_req ? dtx_pkg::EXT_IRQ_VECTOR
                                   : dtx_pkg::NO_VECTOR;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.ext_irq_edge_sel <= dtx_pkg::EDGE_SEL_RST;
      s.timer0_low_byte <= dtx_pkg::BYTE_RST;
      s.timer0_high_byte <= dtx_pkg::BYTE_RST;
      s.timer1_low_byte <= dtx_pkg::BYTE_RST;
      s.timer1_high_byte <= dtx_pkg::BYTE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign ext_irq_req = s.ext_req;
  assign timer0_irq_req = s.t0_req;
  assign timer1_irq_req = s.t1_req;
  assign irq_vector = s.vector;

endmodule : dtx_timers

`default_nettype wire

// ---- common/dtx_pkg.sv ----
package dtx_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0]  IDX_CTL         = 8'h88;
  localparam logic [7:0]  IDX_TMOD        = 8'h89;
  localparam logic [7:0]  IDX_LO0         = 8'h8a;
  localparam logic [7:0]  IDX_LO1         = 8'h8b;
  localparam logic [7:0]  IDX_HI0         = 8'h8c;
  localparam logic [7:0]  IDX_HI1         = 8'h8d;
  localparam logic [7:0]  IDX_EDGE        = 8'h8f;
  localparam logic [7:0]  IDX_IRQEN       = 8'ha8;
  localparam logic [7:0]  IDX_TCON0       = 8'he7;

  // timer_and_irq_control fields
  localparam int unsigned CTL_OV1         = 7;
  localparam int unsigned CTL_RUN1        = 6;
  localparam int unsigned CTL_OV0         = 5;
  localparam int unsigned CTL_RUN0        = 4;
  localparam int unsigned CTL_EXT         = 1;

  // interrupt_enable_0 fields
  localparam int unsigned EN_ALL          = 7;
  localparam int unsigned EN_T1           = 3;
  localparam int unsigned EN_T0           = 1;
  localparam int unsigned EN_EXT          = 0;

  // timer mode register fields
  localparam int unsigned TMOD_T1CT       = 6;
  localparam int unsigned TMOD_M1_LSB     = 4;
  localparam int unsigned TMOD_GATE0      = 3;
  localparam int unsigned TMOD_T0CT       = 2;
  localparam int unsigned TMOD_T0M_LSB    = 0;

  // clock divider register fields
  localparam int unsigned TCON0_T0R_LSB   = 4;
  localparam int unsigned TCON0_T1R_LSB   = 0;

  // edge select field position
  localparam int unsigned EDGE_SEL_LSB    = 0;

  // timer modes
  localparam logic [1:0]  MODE_13BIT      = 2'h0;
  localparam logic [1:0]  MODE_16BIT      = 2'h1;
  localparam logic [1:0]  MODE_RELOAD8    = 2'h2;
  localparam logic [1:0]  MODE_SPLIT8     = 2'h3;

  // trigger edge codes
  localparam logic [1:0]  EDGE_RESERVED   = 2'h0;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_FALL       = 2'h2;
  localparam logic [1:0]  EDGE_BOTH       = 2'h3;
  localparam logic [1:0]  EDGE_SEL_RST    = EDGE_FALL;

  // counting limits
  localparam logic [4:0]  M0_LOW_TOP      = 5'h1f;
  localparam logic [7:0]  BYTE_MAX        = 8'hff;
  localparam logic [15:0] WORD_MAX        = 16'hffff;
  localparam logic [7:0]  BYTE_RST        = 8'h00;

  // cpu tick is core_clk / 12: prescaler counts 0 .. 11
  localparam logic [3:0]  CPU_DIV_LAST    = 4'hb;
  // oscillator divider: rate 0 divides by 2**7
  localparam logic [2:0]  RATE_LOG2_MAX   = 3'h7;

  localparam logic [15:0] EXT_IRQ_VECTOR  = 16'h0003;
  localparam logic [15:0] NO_VECTOR       = 16'h0000;

endpackage : dtx_pkg

// ---- hw/dtx_osc_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module dtx_osc_div (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       osc_tick,
  input  wire logic [2:0] rate,
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } dtx_div_s;

  dtx_div_s   s;
  dtx_div_s   next_s;
  logic [6:0] last;

  always_comb begin
    last = 7'((8'h01 << (dtx_pkg::RATE_LOG2_MAX - rate)) - 8'h01);
    next_s = s;
    next_s.tick = 1'b0;
    if (osc_tick) begin
      // >= so a rate change never strands the count above the limit
      if (s.cnt >= last) begin
        next_s.cnt = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : dtx_osc_div

`default_nettype wire

// ---- tb/dtx_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dtx_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ext_irq_req,
  input  wire logic       timer0_irq_req,
  input  wire logic       timer1_irq_req,
  input  wire logic [3:0] wait_cyc,
  output logic            ext_irq_ack,
  output logic            timer0_irq_ack,
  output logic            timer1_irq_ack
);
  logic [2:0] req;
  logic [2:0] ack;
  logic [2:0] done;
  logic [3:0] cnt [3];

  assign req = {timer1_irq_req, timer0_irq_req, ext_irq_req};
  assign {timer1_irq_ack, timer0_irq_ack, ext_irq_ack} = ack;

  // one ack per request: req lags its flag, so wait for it to drop
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      ack[i] <= 1'b0;
      if (!rst_b || !req[i]) begin
        cnt[i]  <= 4'h0;
        done[i] <= 1'b0;
      end else if (!done[i]) begin
        cnt[i] <= cnt[i] + 4'h1;
        if (cnt[i] == wait_cyc) begin
          ack[i]  <= 1'b1;
          done[i] <= 1'b1;
        end
      end
    end
  end
endmodule : dtx_cpu_model

`default_nettype wire

// ---- tb/dtx_timers_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module dtx_timers_monitor (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        ext_irq_pin,
  input wire logic        ext_irq_ack,
  input wire logic        ext_irq_req,
  input wire logic        timer0_irq_req,
  input wire logic        timer1_irq_req,
  input wire logic [15:0] irq_vector
);
  logic [7:0] ien;
  logic [1:0] esel;
  logic       wr;
  logic       glb_en;
  logic       ext_en;

  // shadows commit on the same edge as the register write
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i[11:10] == 2'h0;
  assign glb_en = ien[dtx_pkg::EN_ALL];
  assign ext_en = glb_en && ien[dtx_pkg::EN_EXT];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ien  <= 8'h00;
      esel <= dtx_pkg::EDGE_SEL_RST;
    end else if (wr && wb_adr_i[9:2] == dtx_pkg::IDX_IRQEN) begin
      ien <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i[9:2] == dtx_pkg::IDX_EDGE) begin
      esel <= wb_dat_i[1:0];
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_armed(hit);
    hit && ext_en && $past(ext_en) && !ext_irq_req && !ext_irq_ack;
  endsequence
  sequence s_taken;
    ext_irq_ack && $stable(ext_irq_pin) ##1 $stable(ext_irq_pin);
  endsequence
  property p_edge(hit);
    s_armed(hit) |-> ##[1:4] ext_irq_req;
  endproperty

  AST_EDGE_RISE: assert property (
    p_edge($rose(ext_irq_pin) && esel == dtx_pkg::EDGE_RISE))
    else $error("no request after rise");
  AST_EDGE_FALL: assert property (
    p_edge($fell(ext_irq_pin) && esel == dtx_pkg::EDGE_FALL))
    else $error("no request after fall");
  AST_EDGE_BOTH: assert property (
    p_edge($changed(ext_irq_pin) && esel == dtx_pkg::EDGE_BOTH))
    else $error("no request after change");
  AST_ACK_CLEAR: assert property (s_taken |=> !ext_irq_req)
    else $error("request kept after ack");
  AST_REQ_HOLD: assert property (
    ext_irq_req && !ext_irq_ack && !$past(ext_irq_ack) && !wb_cyc_i
    && !$past(wb_cyc_i) |=> ext_irq_req)
    else $error("request dropped alone");
  AST_GLOBAL_OFF: assert property (
    !glb_en [*2] |-> !(ext_irq_req || timer0_irq_req || timer1_irq_req))
    else $error("request while all disabled");
  AST_EX0_OFF: assert property (
    !ext_en && !$past(ext_en) |-> !ext_irq_req)
    else $error("external request while disabled");
  AST_VECTOR: assert property (
    irq_vector == (ext_irq_req ? dtx_pkg::EXT_IRQ_VECTOR
                               : dtx_pkg::NO_VECTOR))
    else $error("vector mismatch");
endmodule : dtx_timers_monitor

bind dtx_timers dtx_timers_monitor u_mon (
  .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .ext_irq_pin(ext_irq_pin), .ext_irq_ack(ext_irq_ack),
  .ext_irq_req(ext_irq_req), .timer0_irq_req(timer0_irq_req),
  .timer1_irq_req(timer1_irq_req), .irq_vector(irq_vector));

`default_nettype wire

// ---- tb/tb_dual_timer_with_ext_interrupt.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_dual_timer_with_ext_interrupt;
  logic        core_clk;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pin = 1'b0;
  logic        osc = 1'b0;
  logic [2:0]  iack;
  logic [2:0]  ireq;
  logic [15:0] vec;
  logic [3:0]  wait_cyc = 4'h1;
  logic [7:0]  q;
  logic [79:0] t;
  int          num_errors = 0;
  int          compares = 0;
  int          n_req = 0;
  int          n0;
  // mode tl th run ticks | expected tl0 tl1 th0 th1 control
  logic [79:0] cases [7] = '{
    80'h44_1f_fe_50_01_00_00_ff_ff_50, 80'h44_1f_ff_50_01_00_00_00_00_f0,
    80'h55_ff_fe_50_01_00_00_ff_ff_50, 80'h55_ff_ff_50_01_00_00_00_00_f0,
    80'h66_fe_80_50_02_80_80_80_80_f0, 80'h57_ff_ff_10_01_00_00_ff_00_30,
    80'h55_12_34_00_03_12_12_34_34_00};
  logic [7:0]  pexp [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
  logic [7:0]  offen [2] = '{8'h01, 8'h80};

  dtx_timers dut (
    .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin(pin), .osc_tick(osc),
    .ext_irq_ack(iack[0]), .timer0_irq_ack(iack[1]),
    .timer1_irq_ack(iack[2]), .ext_irq_req(ireq[0]),
    .timer0_irq_req(ireq[1]), .timer1_irq_req(ireq[2]),
    .irq_vector(vec));

  dtx_cpu_model cpu (
    .core_clk(core_clk), .rst_b(rst_b), .ext_irq_req(ireq[0]),
    .timer0_irq_req(ireq[1]), .timer1_irq_req(ireq[2]),
    .wait_cyc(wait_cyc), .ext_irq_ack(iack[0]),
    .timer0_irq_ack(iack[1]), .timer1_irq_ack(iack[2]));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge ireq[0]) n_req++;

  task automatic close_out;
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'h0, idx, 2'h0};
    wdat <= {24'h0, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      osc <= 1'b1;
      @(posedge core_clk);
      osc <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask : ticks

  // long enough for the slowest ack path to settle
  task automatic toggle;
    pin <= ~pin;
    repeat (12) @(posedge core_clk);
  endtask : toggle

  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(dtx_pkg::IDX_IRQEN, 8'h00);
    rd(dtx_pkg::IDX_CTL, 8'h00);
    rd(dtx_pkg::IDX_EDGE, 8'h02);
    wr(dtx_pkg::IDX_EDGE, 8'hff);
    rd(dtx_pkg::IDX_EDGE, 8'h03);
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00); // unmapped reads zero
    wr(dtx_pkg::IDX_CTL, 8'h02);
    rd(dtx_pkg::IDX_CTL, 8'h02);
    wr(dtx_pkg::IDX_CTL, 8'h00);
    rd(dtx_pkg::IDX_CTL, 8'h00);
    foreach (offen[i]) begin
      wr(dtx_pkg::IDX_IRQEN, offen[i]);
      n0 = n_req;
      toggle();
      toggle();
      rd(dtx_pkg::IDX_CTL, 8'h00);
      chk(8'(n_req - n0), 8'h00);
    end
    wr(dtx_pkg::IDX_IRQEN, 8'h81);
    for (int c = 0; c < 4; c++) begin
      wr(dtx_pkg::IDX_EDGE, 8'(c));
      n0 = n_req;
      toggle();
      toggle();
      chk(8'(n_req - n0), pexp[c]);
    end
    rd(dtx_pkg::IDX_CTL, 8'h00);
    wr(dtx_pkg::IDX_IRQEN, 8'h00);
    wr(dtx_pkg::IDX_TCON0, 8'h77);
    foreach (cases[i]) begin
      t = cases[i];
      wr(dtx_pkg::IDX_CTL, 8'h00);
      wr(dtx_pkg::IDX_TMOD, t[79:72]);
      for (int k = 0; k < 4; k++)
        wr(dtx_pkg::IDX_LO0 + 8'(k), (k < 2) ? t[71:64] : t[63:56]);
      wr(dtx_pkg::IDX_CTL, t[55:48]);
      ticks(int'(t[47:40]));
      rd(dtx_pkg::IDX_CTL, t[7:0]);
      for (int k = 0; k < 4; k++)
        rd(dtx_pkg::IDX_LO0 + 8'(k), t[39-8*k -: 8]);
    end
    wr(dtx_pkg::IDX_TMOD, 8'h0f);
    wr(dtx_pkg::IDX_LO0, 8'h10);
    wr(dtx_pkg::IDX_HI0, 8'hff);
    wr(dtx_pkg::IDX_CTL, 8'h50);
    ticks(3);
    repeat (30) @(posedge core_clk);
    rd(dtx_pkg::IDX_CTL, 8'hd0);
    rd(dtx_pkg::IDX_LO0, 8'h10);
    pin <= 1'b1;
    ticks(3);
    rd(dtx_pkg::IDX_LO0, 8'h13);
    wr(dtx_pkg::IDX_IRQEN, 8'h08);
    wr(dtx_pkg::IDX_CTL, 8'h00);
    rd(dtx_pkg::IDX_CTL, 8'h80);
    wait_cyc <= 4'hc;
    wr(dtx_pkg::IDX_IRQEN, 8'h88);
    repeat (30) @(posedge core_clk);
    rd(dtx_pkg::IDX_CTL, 8'h00);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
endmodule : tb_dual_timer_with_ext_interrupt

`default_nettype wire
